// *** logic/ihc_client_hold.sv ***
// Purpose: serial port client hold, overwrite and register map
// Assumes: AHB-Lite single word transfers, pins sampled on clk_sys
// Notes: reads take one wait state, writes none
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module ihc_client_hold
	import ihc_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        scl_in,
	output logic             scl_out,
	output logic             scl_oe,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             irq
);
	import ihc_pkg::*;

	ihc_link_if link ();

	ihc_pin_sync u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.scl_in  (scl_in),
		.sda_in  (sda_in),
		.link    (link.src)
	);

	logic [7:0]       buf_ff,      nxt_buf;
	logic [7:0]       addr_ff,     nxt_addr;
	logic [7:0]       mask_ff,     nxt_mask;
	logic [7:0]       stat_ff,     nxt_stat;
	logic [7:0]       ctl1_ff,     nxt_ctl1;
	logic [7:0]       ctl2_ff,     nxt_ctl2;
	logic [7:0]       ctl3_ff,     nxt_ctl3;
	logic [IRQ_W-1:0] ev_ff,       nxt_ev;
	logic [IRQ_W-1:0] evmask_ff,   nxt_evmask;
	logic [7:0]       shift_ff,    nxt_shift;
	logic [3:0]       cnt_ff,      nxt_cnt;
	logic             is_addr_ff,  nxt_is_addr;
	logic             active_ff,   nxt_active;
	logic             match_ff,    nxt_match;
	logic             wr_ph_ff,    nxt_wr_ph;
	logic             rd_ph_ff,    nxt_rd_ph;
	logic [IDX_W-1:0] idx_ff,      nxt_idx;
	logic [31:0]      hrdata_ff,   nxt_hrdata;
	logic             ready_ff,    nxt_ready;
	logic             scl_oe_ff,   nxt_scl_oe;
	logic             sda_oe_ff,   nxt_sda_oe;
	logic             irq_ff,      nxt_irq;

	logic             mode_spi;
	logic             mode_client;
	logic             spi_client;
	logic             en;
	logic             addr_phase;
	logic             byte_done;
	logic             hold_now;
	logic [7:0]       rx_byte;
	logic             load_buf;
	logic [7:0]       rd_val;

	////////////////////////////////////////////////////////////////////////////
	// Mode decode
	always_comb begin
		en          = ctl1_ff[C1_EN];
		mode_spi    = ctl1_ff[3:0] <= MODE_SPI_LAST;
		spi_client  = (ctl1_ff[3:0] == MODE_SPI_CL) || (ctl1_ff[3:0] == MODE_SPI_CL_NS);
		mode_client = (ctl1_ff[3:0] == MODE_CL7) || (ctl1_ff[3:0] == MODE_CL10)
			|| (ctl1_ff[3:0] == MODE_CL7_IRQ) || (ctl1_ff[3:0] == MODE_CL10_IRQ);
		addr_phase  = hsel & hready & htrans[1];
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read mux
	always_comb begin
		unique case (idx_ff)
			IDX_BUF:      rd_val = buf_ff;
			IDX_ADDR:     rd_val = addr_ff;
			IDX_MASK:     rd_val = mask_ff;
			IDX_STAT:     rd_val = stat_ff;
			IDX_CTL1:     rd_val = ctl1_ff;
			IDX_CTL2:     rd_val = ctl2_ff;
			IDX_CTL3:     rd_val = ctl3_ff;
			IDX_IRQ_STAT: rd_val = {4'h0, ev_ff};
			IDX_IRQ_MASK: rd_val = {4'h0, evmask_ff};
			default:      rd_val = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive path and hold control
	always_comb begin
		nxt_buf     = buf_ff;
		nxt_addr    = addr_ff;
		nxt_mask    = mask_ff;
		nxt_stat    = stat_ff;
		nxt_ctl1    = ctl1_ff;
		nxt_ctl2    = ctl2_ff;
		nxt_ctl3    = ctl3_ff;
		nxt_ev      = ev_ff;
		nxt_evmask  = evmask_ff;
		nxt_shift   = shift_ff;
		nxt_cnt     = cnt_ff;
		nxt_is_addr = is_addr_ff;
		nxt_active  = active_ff;
		nxt_match   = match_ff;
		nxt_sda_oe  = sda_oe_ff;
		byte_done   = 1'b0;
		hold_now    = 1'b0;
		rx_byte     = {shift_ff[6:0], link.sda_lvl};
		load_buf    = 1'b0;

		// Bus side: address phase capture
		nxt_wr_ph  = addr_phase & hwrite;
		nxt_rd_ph  = addr_phase & ~hwrite;
		nxt_idx    = addr_phase ? haddr[IDX_W+1:2] : idx_ff;
		nxt_ready  = ~(addr_phase & ~hwrite);
		nxt_hrdata = hrdata_ff;
		if (rd_ph_ff) begin
			nxt_hrdata = {24'h0, rd_val};
			if (idx_ff == IDX_BUF)
				nxt_stat[ST_BF] = 1'b0;
		end

		// Software writes
		if (wr_ph_ff) begin
			unique case (idx_ff)
				IDX_BUF: begin
					if (active_ff || cnt_ff != 4'h0)
						nxt_ctl1[C1_WRITE_COLLISION] = 1'b1;
					else
						nxt_buf = hwdata[7:0];
				end
				IDX_ADDR:     nxt_addr   = hwdata[7:0];
				IDX_MASK:     nxt_mask   = hwdata[7:0];
				IDX_STAT:     nxt_stat   = {hwdata[7:6], stat_ff[5:0]};
				IDX_CTL1:     nxt_ctl1   = hwdata[7:0];
				IDX_CTL2:     nxt_ctl2   = hwdata[7:0];
				IDX_CTL3:     nxt_ctl3   = {ctl3_ff[C3_ACK_TIME_STATUS], hwdata[6:0]};
				IDX_IRQ_STAT: nxt_ev     = ev_ff & ~hwdata[IRQ_W-1:0];
				IDX_IRQ_MASK: nxt_evmask = hwdata[IRQ_W-1:0];
				default: ;
			endcase
		end

		// I2C client receiver
		if (en && mode_client) begin
			if (link.start) begin
				nxt_active  = 1'b1;
				nxt_is_addr = 1'b1;
				// Start's own SCL fall wraps this to zero
				nxt_cnt     = 4'hf;
				nxt_match   = 1'b0;
			end else if (link.stop) begin
				nxt_active = 1'b0;
				nxt_cnt    = 4'h0;
				nxt_sda_oe = 1'b0;
				nxt_ev[EV_STOP] = 1'b1;
			end else if (active_ff) begin
				if (link.scl_rise && cnt_ff < BITS_PER_BYTE)
					nxt_shift = rx_byte;
				if (link.scl_rise && cnt_ff == BITS_PER_BYTE)
					nxt_ctl3[C3_ACK_TIME_STATUS] = 1'b0;
				if (link.scl_fall) begin
					nxt_cnt = cnt_ff + 4'h1;
					if (cnt_ff == BITS_PER_BYTE - 4'h1) begin
						byte_done = 1'b1;
						if (is_addr_ff) begin
							nxt_match = ((shift_ff[7:1] ^ addr_ff[7:1]) & mask_ff[7:1]) == 7'h00;
							nxt_stat[ST_DA] = 1'b0;
						end else begin
							nxt_stat[ST_DA] = 1'b1;
						end
						hold_now = (is_addr_ff & ctl3_ff[C3_ADDRESS_HOLD_ENABLE]) | (~is_addr_ff & ctl3_ff[C3_DATA_HOLD_ENABLE]);
						if (ctl3_ff[C3_ADDRESS_HOLD_ENABLE] | ctl3_ff[C3_DATA_HOLD_ENABLE])
							nxt_ctl3[C3_ACK_TIME_STATUS] = 1'b1;
						nxt_sda_oe = ~is_addr_ff ? match_ff
							: (((shift_ff[7:1] ^ addr_ff[7:1]) & mask_ff[7:1]) == 7'h00);
					end
					if (cnt_ff == BITS_PER_BYTE) begin
						nxt_sda_oe  = 1'b0;
						nxt_cnt     = 4'h0;
						nxt_is_addr = 1'b0;
						nxt_active  = nxt_match | match_ff;
						if (ctl2_ff[C2_STRETCH] && !is_addr_ff)
							hold_now = 1'b1;
					end
				end
			end
		end else if (en && mode_spi && spi_client) begin
			// SPI client: sample on clock rise
			if (link.scl_rise) begin
				nxt_shift = rx_byte;
				nxt_cnt   = cnt_ff + 4'h1;
				if (cnt_ff == BITS_PER_BYTE - 4'h1) begin
					byte_done = 1'b1;
					nxt_cnt   = 4'h0;
				end
			end
			nxt_active = 1'b0;
		end else begin
			nxt_active = 1'b0;
			nxt_cnt    = 4'h0;
			nxt_sda_oe = 1'b0;
		end

		// Buffer load and overflow
		if (byte_done) begin
			load_buf = ctl3_ff[C3_BUFFER_OVERWRITE_ENABLE] | (mode_spi ? ~stat_ff[ST_BF]
				: ~(stat_ff[ST_BF] | ctl1_ff[C1_OVF]));
			if (stat_ff[ST_BF]) begin
				nxt_ctl1[C1_OVF] = 1'b1;
				nxt_ev[EV_OVF]   = 1'b1;
			end
			if (load_buf) begin
				nxt_buf         = mode_spi ? rx_byte : shift_ff;
				nxt_stat[ST_BF] = 1'b1;
			end
			nxt_ev[EV_BYTE] = 1'b1;
		end

		// Hardware hold beats a simultaneous software release
		if (hold_now) begin
			nxt_ctl1[C1_REL] = 1'b0;
			nxt_ev[EV_HOLD]  = 1'b1;
		end

		nxt_scl_oe = en & mode_client & ~nxt_ctl1[C1_REL];
		nxt_irq    = |(nxt_ev & nxt_evmask);
	end

	////////////////////////////////////////////////////////////////////////////
	// State registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			buf_ff     <= RST_BYTE;
			addr_ff    <= RST_BYTE;
			mask_ff    <= RST_MASK;
			stat_ff    <= RST_BYTE;
			ctl1_ff    <= RST_CTL1;
			ctl2_ff    <= RST_BYTE;
			ctl3_ff    <= RST_BYTE;
			ev_ff      <= '0;
			evmask_ff  <= '0;
			shift_ff   <= RST_BYTE;
			cnt_ff     <= 4'h0;
			is_addr_ff <= 1'b0;
			active_ff  <= 1'b0;
			match_ff   <= 1'b0;
			wr_ph_ff   <= 1'b0;
			rd_ph_ff   <= 1'b0;
			idx_ff     <= '0;
			hrdata_ff  <= 32'h0000_0000;
			ready_ff   <= 1'b1;
			scl_oe_ff  <= 1'b0;
			sda_oe_ff  <= 1'b0;
			irq_ff     <= 1'b0;
		end else begin
			buf_ff     <= nxt_buf;
			addr_ff    <= nxt_addr;
			mask_ff    <= nxt_mask;
			stat_ff    <= nxt_stat;
			ctl1_ff    <= nxt_ctl1;
			ctl2_ff    <= nxt_ctl2;
			ctl3_ff    <= nxt_ctl3;
			ev_ff      <= nxt_ev;
			evmask_ff  <= nxt_evmask;
			shift_ff   <= nxt_shift;
			cnt_ff     <= nxt_cnt;
			is_addr_ff <= nxt_is_addr;
			active_ff  <= nxt_active;
			match_ff   <= nxt_match;
			wr_ph_ff   <= nxt_wr_ph;
			rd_ph_ff   <= nxt_rd_ph;
			idx_ff     <= nxt_idx;
			hrdata_ff  <= nxt_hrdata;
			ready_ff   <= nxt_ready;
			scl_oe_ff  <= nxt_scl_oe;
			sda_oe_ff  <= nxt_sda_oe;
			irq_ff     <= nxt_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign hrdata    = hrdata_ff;
	assign hreadyout = ready_ff;
	assign hresp     = 1'b0;
	assign scl_out   = 1'b0;
	assign scl_oe    = scl_oe_ff;
	assign sda_out   = 1'b0;
	assign sda_oe    = sda_oe_ff;
	assign irq       = irq_ff;
endmodule

// *** logic/ihc_pkg.sv ***
// Purpose: shared constants of the client hold controller
// Assumes: word index times four gives the byte address
// Notes: register indices are printed offsets
package ihc_pkg;
	localparam int          IDX_W          = 10;
	localparam logic [9:0]  IDX_BUF        = 10'h18c;
	localparam logic [9:0]  IDX_ADDR       = 10'h18d;
	localparam logic [9:0]  IDX_MASK       = 10'h18e;
	localparam logic [9:0]  IDX_STAT       = 10'h18f;
	localparam logic [9:0]  IDX_CTL1       = 10'h190;
	localparam logic [9:0]  IDX_CTL2       = 10'h191;
	localparam logic [9:0]  IDX_CTL3       = 10'h192;
	localparam logic [9:0]  IDX_IRQ_STAT   = 10'h193;
	localparam logic [9:0]  IDX_IRQ_MASK   = 10'h194;
	// Control 1 fields
	localparam int          C1_WRITE_COLLISION        = 7;
	localparam int          C1_OVF         = 6;
	localparam int          C1_EN          = 5;
	localparam int          C1_REL         = 4;
	// Control 2 / 3 fields
	localparam int          C2_STRETCH     = 0;
	localparam int          C3_ACK_TIME_STATUS      = 7;
	localparam int          C3_BUFFER_OVERWRITE_ENABLE        = 4;
	localparam int          C3_ADDRESS_HOLD_ENABLE        = 1;
	localparam int          C3_DATA_HOLD_ENABLE        = 0;
	// Status fields
	localparam int          ST_BF          = 0;
	localparam int          ST_DA          = 5;
	// Interrupt status fields
	localparam int          IRQ_W          = 4;
	localparam int          EV_BYTE        = 0;
	localparam int          EV_OVF         = 1;
	localparam int          EV_HOLD        = 2;
	localparam int          EV_STOP        = 3;
	// Modes
	localparam logic [3:0]  MODE_SPI_LAST  = 4'h5;
	localparam logic [3:0]  MODE_CL7       = 4'h6;
	localparam logic [3:0]  MODE_CL10      = 4'h7;
	localparam logic [3:0]  MODE_CL7_IRQ   = 4'he;
	localparam logic [3:0]  MODE_CL10_IRQ  = 4'hf;
	localparam logic [3:0]  MODE_SPI_CL    = 4'h4;
	localparam logic [3:0]  MODE_SPI_CL_NS = 4'h5;
	// Reset values, bit counts and sync depth
	localparam logic [7:0]  RST_BYTE       = 8'h00;
	localparam logic [7:0]  RST_CTL1       = 8'h10;
	localparam logic [7:0]  RST_MASK       = 8'hff;
	localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;
	localparam logic [3:0]  ACK_BIT        = 4'h9;
	localparam int          SYNC_STAGES    = 3;
endpackage

// *** logic/ihc_link_if.sv ***
// Purpose: filtered pin events from the synchroniser to the controller
// Assumes: all signals on clk_sys
// Notes: edge flags are one-cycle pulses
`timescale 1ns/1ps
interface ihc_link_if;
	logic scl_rise;
	logic scl_fall;
	logic sda_lvl;
	logic start;
	logic stop;
	modport src (output scl_rise, output scl_fall, output sda_lvl, output start, output stop);
	modport dst (input scl_rise, input scl_fall, input sda_lvl, input start, input stop);
endinterface

// *** logic/ihc_pin_sync.sv ***
// Purpose: three-stage sampling of bus pins and edge detection
// Assumes: pins asynchronous to clk_sys
// Notes: a level counts once stages two and three agree
`timescale 1ns/1ps
module ihc_pin_sync
	import ihc_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic scl_in,
	input  wire logic sda_in,
	ihc_link_if.src   link
);
	logic [SYNC_STAGES-1:0] scl_sh_ff;
	logic [SYNC_STAGES-1:0] sda_sh_ff;
	logic                   scl_ff;
	logic                   sda_ff;
	logic                   nxt_scl;
	logic                   nxt_sda;

	////////////////////////////////////////////////////////////////////////////
	// Filtered levels
	always_comb begin
		nxt_scl = (scl_sh_ff[1] == scl_sh_ff[2]) ? scl_sh_ff[2] : scl_ff;
		nxt_sda = (sda_sh_ff[1] == sda_sh_ff[2]) ? sda_sh_ff[2] : sda_ff;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			scl_sh_ff <= '1;
			sda_sh_ff <= '1;
			scl_ff    <= 1'b1;
			sda_ff    <= 1'b1;
		end else begin
			scl_sh_ff <= {scl_sh_ff[SYNC_STAGES-2:0], scl_in};
			sda_sh_ff <= {sda_sh_ff[SYNC_STAGES-2:0], sda_in};
			scl_ff    <= nxt_scl;
			sda_ff    <= nxt_sda;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Events
	assign link.scl_rise = nxt_scl & ~scl_ff;
	assign link.scl_fall = ~nxt_scl & scl_ff;
	assign link.sda_lvl  = sda_ff;
	assign link.start    = scl_ff & nxt_scl & sda_ff & ~nxt_sda;
	assign link.stop     = scl_ff & nxt_scl & ~sda_ff & nxt_sda;
endmodule

// *** bench/ihc_client_hold_assertions.sv ***
// Purpose: bus and pin timing checks of the client hold controller
// Assumes: bound to ihc_client_hold, pins pass three sync stages
// Notes: release write seen up to three cycles before the stretch ends
`timescale 1ns/1ps
module ihc_client_hold_assertions (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic        scl_in,
	input  wire logic        scl_out,
	input  wire logic        scl_oe,
	input  wire logic        sda_out,
	input  wire logic        sda_oe
);
	logic wr_dp_ff;
	logic nxt_wr_dp;

	// Write data phase marker
	always_comb begin
		nxt_wr_dp = hsel && hready && htrans[1] && hwrite;
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_dp_ff <= 1'b0;
		end else begin
			wr_dp_ff <= nxt_wr_dp;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
	a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
		else $error("write stalled");
	a_one_wait: assert property ($fell(hreadyout) |=> hreadyout) else $error("wait state too long");
	a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout)) else $error("read data moved");
	a_pins_open: assert property (!scl_out && !sda_out) else $error("pin driven high");
	a_stretch_low: assert property ($rose(scl_oe) |-> !$past(scl_in, 3))
		else $error("stretch not after clock fall");
	a_ack_low: assert property ($rose(sda_oe) |-> !$past(scl_in, 3))
		else $error("ack not after clock fall");
	a_release_write: assert property ($fell(scl_oe) |-> $past(wr_dp_ff) || $past(wr_dp_ff, 2) || $past(wr_dp_ff, 3))
		else $error("clock released without write");
endmodule

bind ihc_client_hold ihc_client_hold_assertions u_chk (
	.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl_in), .scl_out(scl_out),
	.scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe)
);

// *** bench/ihc_host_model.sv ***
// Purpose: serial bus host driving clock and data lines
// Assumes: lines are open drain with pull-ups, release is 1
// Notes: bit period 320 ns, low 220 ns, high 100 ns
`timescale 1ns/1ps
module ihc_host_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      scl_rel,
	output logic      sda_rel,
	output logic      hung
);
	initial begin
		scl_rel = 1'b1;
		sda_rel = 1'b1;
		hung    = 1'b0;
	end

	// One bit, entered with the clock low
	task automatic clk_bit(input logic b, output logic smp);
		int n;
		sda_rel = b;
		#220;
		scl_rel = 1'b1;
		n = 0;
		while (!scl && n < 4000) begin
			#10;
			n++;
		end
		if (n >= 4000)
			hung = 1'b1;
		#100;
		smp = sda;
		scl_rel = 1'b0;
	endtask
	task automatic start_c();
		sda_rel = 1'b1;
		scl_rel = 1'b1;
		#160;
		sda_rel = 1'b0;
		#160;
		scl_rel = 1'b0;
	endtask
	task automatic stop_c();
		sda_rel = 1'b0;
		#220;
		scl_rel = 1'b1;
		#160;
		sda_rel = 1'b1;
		#160;
	endtask
	task automatic send(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], s);
		end
		clk_bit(1'b1, ack);
	endtask
	// Clock stays low between bytes
	task automatic spi(input logic [7:0] b);
		logic s;
		scl_rel = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], s);
		end
	endtask
endmodule

// *** bench/i2c_client_hold_ctrl_tb_top.sv ***
// Purpose: self-checking bench of the client hold controller
// Assumes: one bus slave, hready tied to hreadyout
// Notes: read results checked against a queue of expected bytes
`timescale 1ns/1ps
module i2c_client_hold_ctrl_tb_top;
	import ihc_pkg::*;
	logic        clk_sys;
	logic        rst;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        scl_out;
	logic        scl_oe;
	logic        sda_out;
	logic        sda_oe;
	logic        irq;
	logic        scl_rel;
	logic        sda_rel;
	wire         scl = scl_rel & ~scl_oe;
	wire         sda = sda_rel & ~sda_oe;
	logic [7:0]  exp_q[$];
	logic [7:0]  rd_seen;
	event        rd_ev;
	int          miscompares;
	int          n_checks;
	logic [31:0] seed;
	logic [7:0]  b1;
	logic [7:0]  b2;
	logic        ack;
	logic        host_hung;

	ihc_client_hold DUT (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq));
	ihc_host_model host (.scl(scl), .sda(sda), .scl_rel(scl_rel), .sda_rel(sda_rel), .hung(host_hung));

	initial clk_sys = 1'b0;
	always #20 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, want);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	// One single word transfer
	task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] d);
		int n;
		@(posedge clk_sys);
		htrans <= 2'b10;
		haddr  <= {20'h0, idx, 2'b00};
		hwrite <= wr;
		n = 0;
		do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			finish_test();
		end
		htrans <= 2'b00;
		hwdata <= {24'h0, d};
		do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 100);
		if (hreadyout !== 1'b1) begin
			miscompares++;
			finish_test();
		end
		if (!wr) begin
			rd_seen = hrdata[7:0];
			check({7'h0, |hrdata[31:8]}, 8'h00);
			->rd_ev;
		end
	endtask
	task automatic rd(input logic [9:0] idx, input logic [7:0] want);
		exp_q.push_back(want);
		xfer(idx, 1'b0, 8'h00);
	endtask
	// Bounded wait for a clock stretch
	task automatic wait_hold();
		int n;
		n = 0;
		while (scl_oe !== 1'b1 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		if (scl_oe !== 1'b1) begin
			miscompares++;
			finish_test();
		end
	endtask
	// Software side of a hold
	task automatic on_hold(input logic [7:0] b);
		wait_hold();
		rd(IDX_CTL1, 8'h26);
		rd(IDX_CTL3, 8'h83);
		rd(IDX_BUF, b);
		check({7'h0, irq}, 8'h01);
		check({7'h0, scl_oe}, 8'h01);
		xfer(IDX_IRQ_STAT, 1'b1, 8'h04);
		repeat (2) @(posedge clk_sys);
		check({7'h0, irq}, 8'h00);
		xfer(IDX_CTL1, 1'b1, 8'h36);
	endtask

	always @(rd_ev) check(rd_seen, exp_q.pop_front());

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		hsel = 1'b1;
		haddr = '0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = '0;
		seed = 32'h83b3;
		miscompares = 0;
		n_checks = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'b0;
		rd(IDX_CTL1, RST_CTL1);
		rd(IDX_MASK, RST_MASK);
		rd(IDX_CTL3, RST_BYTE);
		rd(10'h1a0, 8'h00);
		b1 = rnd();
		xfer(IDX_ADDR, 1'b1, b1);
		rd(IDX_ADDR, b1);
		// Client receive with both holds
		xfer(IDX_ADDR, 1'b1, 8'ha0);
		xfer(IDX_CTL3, 1'b1, 8'h03);
		xfer(IDX_IRQ_MASK, 1'b1, 8'h04);
		xfer(IDX_CTL1, 1'b1, 8'h36);
		host.start_c();
		fork
			host.send(8'ha0, ack);
			on_hold(8'ha0);
		join
		check({7'h0, ack}, 8'h00);
		b2 = rnd();
		xfer(IDX_CTL2, 1'b1, 8'h01);
		fork
			host.send(b2, ack);
			on_hold(b2);
		join
		rd(IDX_CTL3, 8'h03);
		// Stretch after the data byte's acknowledge
		wait_hold();
		rd(IDX_CTL1, 8'h26);
		xfer(IDX_CTL2, 1'b1, 8'h00);
		xfer(IDX_CTL1, 1'b1, 8'h36);
		host.stop_c();
		// SPI receive, holds set, overwrite on
		xfer(IDX_CTL3, 1'b1, 8'h13);
		xfer(IDX_CTL1, 1'b1, 8'h34);
		b1 = rnd();
		b2 = rnd();
		host.spi(b1);
		host.spi(b2);
		repeat (8) @(posedge clk_sys);
		check({7'h0, scl_oe}, 8'h00);
		rd(IDX_CTL1, 8'h74);
		rd(IDX_BUF, b2);
		check({7'h0, host_hung}, 8'h00);
		@(posedge clk_sys);
		finish_test();
	end
endmodule
